// File: rtl/tile_control.sv
// tile control register with rgmii clocking, low-power divider and usb select
// assumes an AXI4-Lite master, pll lock and thread state synchronous to core_clk
//
// Overview of operation
// RULE_01: eight-bit tx data delay field, resets zero
// RULE_02: tx clock rises when counter hits divider
// RULE_03: tx clock falls at divider shifted right
// RULE_04: software writes divide ratio minus one
// RULE_05: rgmii ports connected only when enabled
// RULE_06: divider enable divides pll clock
// RULE_07: dynamic mode divides only when threads paused
// RULE_08: static mode divides always, mode resets zero
// RULE_09: usb select one means utmi, zero ulpi
// RULE_10: ulpi support active while its bit set
// RULE_11: async reset, then wait lock, then boot
// RULE_12: reset held at least 100 ns
// RULE_13: reserved bits read zero, writes ignored
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tile_control
	import tile_ctrl_pkg::*;
#(
	parameter int RGMII_DW = 5,
	parameter int LP_RATIO = LP_DIV_RATIO
) (
	// clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  sys_rst,
	// axi4-lite write address
	input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]            s_axi_awprot,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	// axi4-lite write response
	output logic      [1:0]            s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	// axi4-lite read address
	input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]            s_axi_arprot,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	// axi4-lite read data
	output logic      [31:0]           s_axi_rdata,
	output logic      [1:0]            s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// boot sequencing
	input  wire logic                  pllLock,
	input  wire logic [1:0]            bootModePin,
	output logic                       bootGo,
	output logic      [1:0]            bootMode,
	// low-power divider
	input  wire logic                  allPaused,
	output logic                       tileClkEn,
	output logic                       divActive,
	// rgmii mac side
	input  wire logic [RGMII_DW-1:0]   macTx,
	output logic      [RGMII_DW-1:0]   macRx,
	// rgmii phy side
	input  wire logic [RGMII_DW-1:0]   rgmiiRx,
	output logic      [RGMII_DW-1:0]   rgmiiTx,
	output logic                       rgmiiTxClk,
	// usb phy mode
	output logic                       utmiSel,
	output logic                       ulpiEn
);

	// ============================================================
	// state
	typedef struct packed {
		boot_e                 boot;
		logic                  bootGo;
		logic [1:0]            bootMode;
		logic [31:0]           ctrl;
		logic                  awHeld;
		logic [AXI_ADDR_W-1:0] awAddr;
		logic                  wHeld;
		logic [31:0]           wData;
		logic [3:0]            wStrb;
		logic                  awReady;
		logic                  wReady;
		logic                  bValid;
		logic [1:0]            bResp;
		logic                  arReady;
		logic                  rValid;
		logic [31:0]           rData;
		logic [1:0]            rResp;
	} top_s;

	localparam top_s ST_RESET = '{
		boot:     BOOT_WAIT_LOCK,
		bootGo:   1'b0,
		bootMode: 2'h0,
		ctrl:     CTRL_RESET,
		awHeld:   1'b0,
		awAddr:   '0,
		wHeld:    1'b0,
		wData:    32'h0000_0000,
		wStrb:    4'h0,
		awReady:  1'b0,
		wReady:   1'b0,
		bValid:   1'b0,
		bResp:    RESP_OKAY,
		arReady:  1'b0,
		rValid:   1'b0,
		rData:    32'h0000_0000,
		rResp:    RESP_OKAY
	};

	top_s        st_r;
	top_s        st_nxt;
	logic [31:0] merged;

	tile_cfg_if cfgBus ();

	// ============================================================
	// handshakes
	// named once so the next-state logic reads as the bus rules
	logic awTake;
	logic wTake;
	logic commitNow;
	logic bDone;
	logic arTake;
	logic rDone;

	assign awTake    = s_axi_awvalid && st_r.awReady;
	assign wTake     = s_axi_wvalid && st_r.wReady;
	assign commitNow = st_r.awHeld && st_r.wHeld && !st_r.bValid;
	assign bDone     = st_r.bValid && s_axi_bready;
	assign arTake    = s_axi_arvalid && st_r.arReady;
	assign rDone     = st_r.rValid && s_axi_rready;

	// ============================================================
	// address decode
	// only the word index is compared; the two low address bits are ignored
	// unmapped words answer with an error and leave the register alone
	logic awHit;
	logic arHit;

	assign awHit = (st_r.awAddr[AXI_ADDR_W-1:2] == CTRL_ADDR[AXI_ADDR_W-1:2]);
	assign arHit = (s_axi_araddr[AXI_ADDR_W-1:2] == CTRL_ADDR[AXI_ADDR_W-1:2]);

	// ============================================================
	// write byte lanes
	// a write merges only the strobed bytes; reserved bits are masked after
	logic [31:0] laneMask;
	genvar       gl;
	generate
		for (gl = 0; gl < 4; gl++) begin : g_lane
			assign laneMask[gl*8 +: 8] = {8{st_r.wStrb[gl]}};
		end
	endgenerate

	// ============================================================
	// next state
	always_comb begin
		st_nxt = st_r;
		merged = st_r.ctrl;
		st_nxt.bootGo = 1'b0;

		// boot waits for pll lock after reset release; straps caught here
		unique case (st_r.boot)
			BOOT_WAIT_LOCK: begin
				if (pllLock) begin
					st_nxt.boot     = BOOT_RUN; // RULE_11
					st_nxt.bootGo   = 1'b1;
					st_nxt.bootMode = bootModePin;
				end
			end
			BOOT_RUN: begin
				st_nxt.boot = BOOT_RUN;
			end
			default: begin
				st_nxt.boot = BOOT_WAIT_LOCK;
			end
		endcase

		// write channels are taken independently, in either order
		if (awTake) begin
			st_nxt.awHeld = 1'b1;
			st_nxt.awAddr = s_axi_awaddr;
		end
		if (wTake) begin
			st_nxt.wHeld = 1'b1;
			st_nxt.wData = s_axi_wdata;
			st_nxt.wStrb = s_axi_wstrb;
		end

		// commit once both halves are held and no response is pending
		if (commitNow) begin
			st_nxt.awHeld = 1'b0;
			st_nxt.wHeld  = 1'b0;
			st_nxt.bValid = 1'b1;
			if (awHit) begin
				merged       = (st_r.ctrl & ~laneMask) | (st_r.wData & laneMask);
				st_nxt.ctrl  = merged & CTRL_WMASK; // RULE_13
				st_nxt.bResp = RESP_OKAY;
			end else begin
				st_nxt.bResp = RESP_SLVERR;
			end
		end else if (bDone) begin
			st_nxt.bValid = 1'b0;
		end

		// read: one outstanding, answered the cycle after acceptance
		if (arTake) begin
			st_nxt.rValid = 1'b1;
			if (arHit) begin
				st_nxt.rData = st_r.ctrl & CTRL_WMASK; // RULE_13
				st_nxt.rResp = RESP_OKAY;
			end else begin
				st_nxt.rData = 32'h0000_0000;
				st_nxt.rResp = RESP_SLVERR;
			end
		end else if (rDone) begin
			st_nxt.rValid = 1'b0;
		end

		// readies are registered so every bus output comes from a flop
		st_nxt.awReady = !st_nxt.awHeld && !st_nxt.bValid;
		st_nxt.wReady  = !st_nxt.wHeld && !st_nxt.bValid;
		st_nxt.arReady = !st_nxt.rValid;
	end

	// ============================================================
	// registers
	// reset asserts at once, independent of the clock; the pin is held
	// long enough by the system, so no stretch counter is kept here
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= ST_RESET; // RULE_11 RULE_12
		end else begin
			st_r <= st_nxt;
		end
	end

	// ============================================================
	// field distribution
	// the divider field holds ratio minus one; nothing here adds it back
	assign cfgBus.txDiv   = st_r.ctrl[TXDIV_LSB +: TXDIV_W]; // RULE_04
	assign cfgBus.txDelay = st_r.ctrl[TXDLY_LSB +: TXDLY_W];
	assign cfgBus.rgmiiEn = st_r.ctrl[RGMII_EN_BIT];
	assign cfgBus.divEn   = st_r.ctrl[DIV_EN_BIT];
	assign cfgBus.dynMode = st_r.ctrl[DYN_MODE_BIT];

	// ============================================================
	// clocking blocks
	rgmii_tx_gen #(
		.DW        (RGMII_DW)
	) u_rgmii (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.cfg       (cfgBus.rgmii),
		.macTx     (macTx),
		.macRx     (macRx),
		.phyRx     (rgmiiRx),
		.phyTx     (rgmiiTx),
		.txClk     (rgmiiTxClk)
	);

	lp_clk_div #(
		.RATIO     (LP_RATIO)
	) u_lpdiv (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.cfg       (cfgBus.lpdiv),
		.allPaused (allPaused),
		.tileClkEn (tileClkEn),
		.divActive (divActive)
	);

	// ============================================================
	// outputs
	assign s_axi_awready = st_r.awReady;
	assign s_axi_wready  = st_r.wReady;
	assign s_axi_bvalid  = st_r.bValid;
	assign s_axi_bresp   = st_r.bResp;
	assign s_axi_arready = st_r.arReady;
	assign s_axi_rvalid  = st_r.rValid;
	assign s_axi_rdata   = st_r.rData;
	assign s_axi_rresp   = st_r.rResp;

	// ============================================================
	// boot and usb select
	assign bootGo        = st_r.bootGo;
	assign bootMode      = st_r.bootMode;
	assign utmiSel       = st_r.ctrl[UTMI_SEL_BIT]; // RULE_09
	assign ulpiEn        = st_r.ctrl[ULPI_EN_BIT]; // RULE_10

endmodule // tile_control
`default_nettype wire

// File: rtl/tile_ctrl_pkg.sv
// tile control package: register map, field layout, reset values, timing
// assumes a 32-bit AXI4-Lite register port and one 100 MHz core clock
package tile_ctrl_pkg;

	// ============================================================
	// bus and register map
	localparam int          AXI_ADDR_W    = 8;
	localparam int          AXI_DATA_W    = 32;
	localparam int          CTRL_IDX      = 2;
	localparam logic [7:0]  CTRL_ADDR     = 8'(CTRL_IDX * 4);
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// ============================================================
	// control register fields
	localparam int          TXDLY_LSB     = 18;
	localparam int          TXDLY_W       = 8;
	localparam int          TXDIV_LSB     = 9;
	localparam int          TXDIV_W       = 9;
	localparam int          RGMII_EN_BIT  = 8;
	localparam int          DYN_MODE_BIT  = 5;
	localparam int          DIV_EN_BIT    = 4;
	localparam int          UTMI_SEL_BIT  = 2;
	localparam int          ULPI_EN_BIT   = 1;
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
	localparam logic [31:0] CTRL_WMASK    = 32'h03FF_FF36;

	// ============================================================
	// timing
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          RST_MIN_NS    = 100;
	localparam int          RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          LP_DIV_RATIO  = 4;

	// ============================================================
	// boot sequencing after reset
	typedef enum logic [1:0] {
		BOOT_WAIT_LOCK = 2'b01,
		BOOT_RUN       = 2'b10
	} boot_e;

endpackage

// File: rtl/tile_cfg_if.sv
// tile config carrier: control fields from the register to the clock blocks
// assumes one clock domain; fields are plain register outputs
`timescale 1ns/1ps
`default_nettype none
interface tile_cfg_if;
	import tile_ctrl_pkg::*;
	logic [TXDLY_W-1:0] txDelay;
	logic [TXDIV_W-1:0] txDiv;
	logic               rgmiiEn;
	logic               divEn;
	logic               dynMode;
	modport src   (output txDelay, txDiv, rgmiiEn, divEn, dynMode);
	modport rgmii (input txDelay, txDiv, rgmiiEn);
	modport lpdiv (input divEn, dynMode);
endinterface
`default_nettype wire

// File: rtl/rgmii_tx_gen.sv
// rgmii transmit clock generator, data delay line and port gating
// assumes core_clk is the pll output clock that times the tx divider
`timescale 1ns/1ps
`default_nettype none
module rgmii_tx_gen
	import tile_ctrl_pkg::*;
#(
	parameter int DW = 5
) (
	// clock and reset
	input  wire logic          core_clk,
	input  wire logic          sys_rst,
	// configuration
	tile_cfg_if.rgmii          cfg,
	// mac side
	input  wire logic [DW-1:0] macTx,
	output logic      [DW-1:0] macRx,
	// phy side
	input  wire logic [DW-1:0] phyRx,
	output logic      [DW-1:0] phyTx,
	output logic               txClk
);
	localparam int DEPTH = 2 ** TXDLY_W;

	typedef struct packed {
		logic [TXDIV_W-1:0] cnt;
		logic               clk;
		logic [TXDLY_W-1:0] wp;
		logic [DW-1:0]      tx;
		logic [DW-1:0]      rx;
	} gen_s;

	gen_s          st_r;
	gen_s          st_nxt;
	logic [DW-1:0] dlyMem [DEPTH];

	// delay line memory is not reset; stale words only appear in the first delay-field cycles after enabling
	always_ff @(posedge core_clk) begin
		dlyMem[st_r.wp] <= macTx;
	end

	always_comb begin
		st_nxt = st_r;
		if (cfg.rgmiiEn) begin
			st_nxt.cnt = (st_r.cnt >= cfg.txDiv) ? '0 : st_r.cnt + 1'b1;
			// rising point wins when the field is zero and both points coincide
			if (st_r.cnt == cfg.txDiv) begin
				st_nxt.clk = 1'b1; // RULE_02
			end else if (st_r.cnt == (cfg.txDiv >> 1)) begin
				st_nxt.clk = 1'b0; // RULE_03
			end
			st_nxt.wp = st_r.wp + 1'b1;
			// total latency is delay field plus one cycle
			st_nxt.tx = (cfg.txDelay == '0) ? macTx : dlyMem[st_r.wp - cfg.txDelay]; // RULE_01
			st_nxt.rx = phyRx;
		end else begin
			// ports disconnected: drive low and park the counter
			st_nxt.cnt = '0; // RULE_05
			st_nxt.clk = 1'b0;
			st_nxt.tx  = '0;
			st_nxt.rx  = '0;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign phyTx = st_r.tx;
	assign macRx = st_r.rx;
	assign txClk = st_r.clk;
endmodule // rgmii_tx_gen
`default_nettype wire

// File: rtl/lp_clk_div.sv
// low-power divider: turns the pll clock into a tile clock enable
// assumes allPaused is synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module lp_clk_div
	import tile_ctrl_pkg::*;
#(
	parameter int RATIO = LP_DIV_RATIO
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic sys_rst,
	// configuration and thread state
	tile_cfg_if.lpdiv cfg,
	input  wire logic allPaused,
	// outputs
	output logic      tileClkEn,
	output logic      divActive
);
	localparam int CW = (RATIO > 1) ? $clog2(RATIO) : 1;

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          en;
		logic          act;
	} div_s;

	div_s st_r;
	div_s st_nxt;
	logic act;

	always_comb begin
		// static mode divides always, dynamic only while all threads pause
		act    = cfg.divEn & (~cfg.dynMode | allPaused); // RULE_06 RULE_07 RULE_08
		st_nxt = st_r;
		st_nxt.act = act;
		if (act) begin
			st_nxt.en  = (st_r.cnt == CW'(RATIO - 1));
			st_nxt.cnt = st_nxt.en ? '0 : st_r.cnt + 1'b1;
		end else begin
			st_nxt.en  = 1'b1;
			st_nxt.cnt = '0;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= '{cnt: '0, en: 1'b1, act: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tileClkEn = st_r.en;
	assign divActive = st_r.act;
endmodule // lp_clk_div
`default_nettype wire

// File: bench/eth_phy_model.sv
// phy partner: receive lines that change every cycle
// assumes one clock; the pattern never holds still, so stale data is visible
`timescale 1ns/1ps
`default_nettype none
module eth_phy_model (
	// clock
	input  wire logic       core_clk,
	// receive pins toward the tile
	output logic      [4:0] rgmiiRx
);
	initial rgmiiRx = 5'h0_015;
	// ============================================================
	// lfsr pattern
	always @(posedge core_clk) begin
		rgmiiRx <= {rgmiiRx[3:0], rgmiiRx[4] ^ rgmiiRx[2]};
	end
endmodule // eth_phy_model
`default_nettype wire

// File: bench/tile_control_props.sv
// checker for tile_control: shadows the control word from write responses
// assumes a bind onto tile_control and one clock domain
`timescale 1ns/1ps
`default_nettype none
module tile_control_props
	import tile_ctrl_pkg::*;
#(
	parameter int RGMII_DW = 5
) (
	// clock and reset
	input wire logic                core_clk,
	input wire logic                sys_rst,
	// bus
	input wire logic [31:0]         s_axi_wdata,
	input wire logic [3:0]          s_axi_wstrb,
	input wire logic                s_axi_wvalid,
	input wire logic                s_axi_wready,
	input wire logic [1:0]          s_axi_bresp,
	input wire logic                s_axi_bvalid,
	input wire logic [31:0]         s_axi_rdata,
	input wire logic                s_axi_rvalid,
	// status and outputs
	input wire logic                pllLock,
	input wire logic                bootGo,
	input wire logic                allPaused,
	input wire logic                tileClkEn,
	input wire logic                divActive,
	input wire logic [RGMII_DW-1:0] macTx,
	input wire logic [RGMII_DW-1:0] macRx,
	input wire logic [RGMII_DW-1:0] rgmiiRx,
	input wire logic [RGMII_DW-1:0] rgmiiTx,
	input wire logic                rgmiiTxClk,
	input wire logic                utmiSel,
	input wire logic                ulpiEn
);
	// ============================================================
	// shadow state
	logic [31:0]         wd, ctrl;
	logic [3:0]          ws;
	logic [9:0]          quiet, runLen;
	logic                prevClk;
	logic [RGMII_DW-1:0] hist [256];
	wire  logic [31:0]   bm = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
	wire  logic [8:0]    dv = ctrl[TXDIV_LSB +: TXDIV_W];
	wire  logic          on = ctrl[RGMII_EN_BIT];
	always_ff @(posedge core_clk) begin
		if (s_axi_wvalid && s_axi_wready) begin
			wd <= s_axi_wdata;
			ws <= s_axi_wstrb;
		end
		hist[0] <= macTx;
		for (int i = 1; i < 256; i++) hist[i] <= hist[i-1];
	end
	// quiet counts cycles since the last response so fields have settled
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl <= '0;
			quiet <= '0;
			runLen <= '0;
			prevClk <= 1'b0;
		end else begin
			if (s_axi_bvalid && s_axi_bresp == RESP_OKAY) ctrl <= ((ctrl & ~bm) | (wd & bm)) & CTRL_WMASK;
			quiet <= s_axi_bvalid ? 10'h0 : (quiet == 10'h3FF ? quiet : quiet + 10'h1);
			runLen <= (rgmiiTxClk != prevClk) ? 10'h1 : runLen + 10'h1;
			prevClk <= rgmiiTxClk;
		end
	end
	// ============================================================
	// properties
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	utmi_sel_a: assert property (!s_axi_bvalid |-> utmiSel == ctrl[UTMI_SEL_BIT])
		else $error("usb select mismatch");
	ulpi_en_a: assert property (!s_axi_bvalid |-> ulpiEn == ctrl[ULPI_EN_BIT])
		else $error("ulpi enable mismatch");
	rsvd_zero_a: assert property (s_axi_rvalid |-> (s_axi_rdata & ~CTRL_WMASK) == '0)
		else $error("reserved bits read nonzero");
	port_off_a: assert property (!on && quiet > 2 |-> !rgmiiTxClk && rgmiiTx == '0 && macRx == '0)
		else $error("rgmii ports active while disabled");
	rx_pass_a: assert property (on && quiet > 2 |-> macRx == $past(rgmiiRx))
		else $error("receive path not passed");
	tx_delay_a: assert property (on && quiet > 300 |-> rgmiiTx == hist[ctrl[TXDLY_LSB +: TXDLY_W]])
		else $error("transmit delay wrong");
	clk_high_a: assert property (on && quiet > 600 && $fell(rgmiiTxClk) |-> runLen == 10'(dv / 2 + 1))
		else $error("tx clock high time wrong");
	clk_low_a: assert property (on && quiet > 600 && $rose(rgmiiTxClk) |-> runLen == 10'(dv - dv / 2))
		else $error("tx clock low time wrong");
	div_mode_a: assert property (quiet > 2 |-> divActive == $past(ctrl[DIV_EN_BIT] && (!ctrl[DYN_MODE_BIT] || allPaused)))
		else $error("divider state wrong");
	en_full_a: assert property (!divActive [*3] |-> tileClkEn)
		else $error("clock enable dropped while undivided");
	en_div_a: assert property (divActive [*3] |-> !(tileClkEn && $past(tileClkEn)))
		else $error("clock enable not divided");
	boot_lock_a: assert property (bootGo |-> $past(pllLock) ##1 !bootGo)
		else $error("boot start without lock");
	cover property (bootGo);
	cover property (divActive && allPaused);
	cover property (on && quiet > 600 && $fell(rgmiiTxClk));
endmodule // tile_control_props
bind tile_control tile_control_props #(.RGMII_DW(RGMII_DW)) u_props (.core_clk, .sys_rst,
	.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_rdata, .s_axi_rvalid, .pllLock, .bootGo, .allPaused, .tileClkEn, .divActive,
	.macTx, .macRx, .rgmiiRx, .rgmiiTx, .rgmiiTxClk, .utmiSel, .ulpiEn);
`default_nettype wire

// File: bench/tb_tile_control.sv
// testbench for tile_control: bus tasks, random control words, rgmii and divider
// assumes the checker is bound in and the phy model drives the receive pins
`timescale 1ns/1ps
`default_nettype none
module tb_tile_control;
	import tile_ctrl_pkg::*;
	// ============================================================
	// signals
	logic        core_clk, sys_rst, pllLock, allPaused, bootGo, tileClkEn, divActive;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        rgmiiTxClk, utmiSel, ulpiEn;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [2:0]  s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata, v, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, bootModePin, bootMode, r;
	logic [4:0]  macTx, macRx, rgmiiRx, rgmiiTx;
	int          fail_count, tests_run, cyc, n, dd;
	tile_control u_dut (.core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pllLock,
		.bootModePin, .bootGo, .bootMode, .allPaused, .tileClkEn, .divActive, .macTx, .macRx,
		.rgmiiRx, .rgmiiTx, .rgmiiTxClk, .utmiSel, .ulpiEn);
	eth_phy_model u_phy (.core_clk, .rgmiiRx);
	initial begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	// ============================================================
	// helpers
	function automatic logic [31:0] expReg(input logic [31:0] w);
		return w & CTRL_WMASK;
	endfunction
	function automatic logic expAct(input logic en, dyn, p);
		return en && (!dyn || p);
	endfunction
	task automatic chk(input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// bready and rready stay high throughout, so the answer is taken when seen
	task automatic wr(input logic [7:0] a, input logic [31:0] w, output logic [1:0] rsp);
		s_axi_awaddr <= a;
		s_axi_wdata <= w;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] w, output logic [1:0] rsp);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		w = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ============================================================
	// timeout and random transmit data
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		macTx <= 5'($urandom);
		if (cyc == 20000) begin
			fail_count++;
			results;
		end
	end
	// ============================================================
	// main sequence
	initial begin
		v = $urandom(85);
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, pllLock, allPaused} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot, macTx} = '0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
		{fail_count, tests_run, cyc} = '0;
		bootModePin = 2'($urandom);
		sys_rst = 1'b1;
		repeat (RST_MIN_CYC + 1) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (5) @(posedge core_clk);
		chk(32'(bootGo), 32'h0);
		pllLock <= 1'b1;
		@(posedge core_clk iff bootGo === 1'b1);
		chk(32'(bootMode), 32'(bootModePin));
		rd(CTRL_ADDR, v, r);
		chk(v, CTRL_RESET);
		for (int i = 0; i < 40; i++) begin
			d = (i == 0) ? 32'hFFFF_FFFF : $urandom;
			wr(CTRL_ADDR, d, r);
			chk(32'(r), 32'(RESP_OKAY));
			rd(CTRL_ADDR, v, r);
			chk(32'(r), 32'(RESP_OKAY));
			chk(v, expReg(d));
			chk(32'({utmiSel, ulpiEn}), 32'(d[2:1]));
		end
		wr(8'h0C, 32'hFFFF_FFFF, r);
		chk(32'(r), 32'(RESP_SLVERR));
		rd(8'h0C, v, r);
		chk(32'(r), 32'(RESP_SLVERR));
		chk(v, 32'h0);
		rd(CTRL_ADDR, v, r);
		chk(v, expReg(d));
		for (int k = 0; k < 3; k++) begin
			dd = (k == 0) ? 2 : (k == 1) ? 7 : 3 + int'($urandom % 30);
			d = (32'($urandom % 256) << TXDLY_LSB) | (32'(dd - 1) << TXDIV_LSB);
			wr(CTRL_ADDR, d | (32'h1 << RGMII_EN_BIT), r);
			repeat (620) @(posedge core_clk);
			@(posedge core_clk iff rgmiiTxClk === 1'b0);
			@(posedge core_clk iff rgmiiTxClk === 1'b1);
			n = 0;
			do begin @(posedge core_clk); n++; end while (rgmiiTxClk !== 1'b0);
			do begin @(posedge core_clk); n++; end while (rgmiiTxClk !== 1'b1);
			chk(32'(n), 32'(dd));
		end
		for (int m = 0; m < 8; m++) begin
			allPaused <= m[2];
			wr(CTRL_ADDR, (32'(m[0]) << DIV_EN_BIT) | (32'(m[1]) << DYN_MODE_BIT), r);
			repeat (3) @(posedge core_clk);
			chk(32'(divActive), 32'(expAct(m[0], m[1], m[2])));
			n = 0;
			repeat (8) begin @(posedge core_clk); n += int'(tileClkEn); end
			chk(32'(n), expAct(m[0], m[1], m[2]) ? 32'(8 / LP_DIV_RATIO) : 32'h8);
		end
		results;
	end
endmodule // tb_tile_control
`default_nettype wire
